//--- sram_port_pkg.sv
package sram_port_pkg;

    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int ADDR_W = 18;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int BURST_W = 2;

    // ----------------------------------------
    // Pipeline position and burst constants
    // ----------------------------------------
    localparam int WR_DATA_LAG = 2;
    localparam logic BURST_INTERLEAVED = 1'b1;
    localparam logic [1:0] BURST_ZERO = 2'h0;
    localparam logic [1:0] BURST_ONE = 2'h1;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_READ,
        OP_WRITE
    } op_t;

endpackage

//--- burst_step_if.sv
`timescale 1ns/1ps
`default_nettype none

interface burst_step_if;
    logic interleaved;
    logic [1:0] start;
    logic [1:0] count;
    logic [1:0] offset;

    modport ctrl (
        output interleaved,
        output start,
        output count,
        input offset
    );

    modport calc (
        input interleaved,
        input start,
        input count,
        output offset
    );
endinterface

`default_nettype wire

//--- burst_order_calc.sv
`timescale 1ns/1ps
`default_nettype none

module burst_order_calc (
    burst_step_if.calc bus
);

    // ----------------------------------------
    // Burst offset from start and step count
    // ----------------------------------------
    always_comb
    begin
        if (bus.interleaved == sram_port_pkg::BURST_INTERLEAVED)
        begin
            bus.offset = bus.start ^ bus.count;
        end
        else
        begin
            bus.offset = bus.start + bus.count;
        end
    end

endmodule

`default_nettype wire

//--- sync_pipelined_sram_port.sv
`timescale 1ns/1ps
`default_nettype none

module sync_pipelined_sram_port #(
    parameter int ADDR_W = sram_port_pkg::ADDR_W,
    parameter int LANES = sram_port_pkg::LANES,
    parameter int LANE_W = sram_port_pkg::LANE_W
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic burst_addr_bit0_i,
    input wire logic burst_addr_bit1_i,
    input wire logic lane_a_write_sel_n_i,
    input wire logic lane_b_write_sel_n_i,
    input wire logic lane_c_write_sel_n_i,
    input wire logic lane_d_write_sel_n_i,
    input wire logic write_n_i,
    input wire logic advance_or_load_i,
    input wire logic clock_qualify_n_i,
    input wire logic select_first_n_i,
    input wire logic select_second_i,
    input wire logic select_third_n_i,
    input wire logic output_enable_n_i,
    input wire logic burst_order_i,
    input wire logic [LANES*LANE_W-1:0] data_in_i,
    output logic [LANES*LANE_W-1:0] data_out_o,
    output logic data_oe_o,
    input wire logic [LANES-1:0] lane_parity_in_i,
    output logic [LANES-1:0] lane_parity_out_o,
    output logic lane_parity_oe_o
);

    localparam int FULL_W = ADDR_W + sram_port_pkg::BURST_W;
    localparam int DEPTH = 1 << FULL_W;
    localparam int LAG = sram_port_pkg::WR_DATA_LAG;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    localparam int SYNC_W = FULL_W + LANES + 8;
    logic [SYNC_W-1:0] pin_meta_r;
    logic [SYNC_W-1:0] pin_sync_r;
    logic [LANES*LANE_W-1:0] din_meta_r;
    logic [LANES*LANE_W-1:0] din_sync_r;
    logic [LANES-1:0] par_meta_r;
    logic [LANES-1:0] par_sync_r;
    logic [SYNC_W-1:0] pin_raw;

    assign pin_raw = {addr_i, burst_addr_bit1_i, burst_addr_bit0_i,
                      lane_d_write_sel_n_i, lane_c_write_sel_n_i,
                      lane_b_write_sel_n_i, lane_a_write_sel_n_i,
                      write_n_i, advance_or_load_i, clock_qualify_n_i,
                      select_first_n_i, select_second_i, select_third_n_i,
                      output_enable_n_i, burst_order_i};

    always_ff @(posedge sys_clk_i)
    begin
        pin_meta_r <= pin_raw;
        pin_sync_r <= pin_meta_r;
        din_meta_r <= data_in_i;
        din_sync_r <= din_meta_r;
        par_meta_r <= lane_parity_in_i;
        par_sync_r <= par_meta_r;
    end

    logic [FULL_W-1:0] s_addr;
    logic [LANES-1:0] s_lane_n;
    logic s_we_n;
    logic s_adv;
    logic s_cq_n;
    logic s_sel;
    logic s_oe_n;
    logic s_order;

    assign s_addr = pin_sync_r[SYNC_W-1 -: FULL_W];
    assign s_lane_n = pin_sync_r[8 +: LANES];
    assign s_we_n = pin_sync_r[7];
    assign s_adv = pin_sync_r[6];
    assign s_cq_n = pin_sync_r[5];
    assign s_sel = !pin_sync_r[4] && pin_sync_r[3] && !pin_sync_r[2];
    assign s_oe_n = pin_sync_r[1];
    assign s_order = pin_sync_r[0];

    // ----------------------------------------
    // Qualified edge
    // ----------------------------------------
    logic tick;
    assign tick = reset_n_i && !s_cq_n;

    // ----------------------------------------
    // Burst offset unit
    // ----------------------------------------
    burst_step_if step ();
    burst_order_calc u_order (
        .bus(step)
    );

    // ----------------------------------------
    // Access control state
    // ----------------------------------------
    logic [ADDR_W-1:0] base_r, base_nxt;
    logic [1:0] start_r, start_nxt;
    logic [1:0] count_r, count_nxt;
    sram_port_pkg::op_t op_r, op_nxt;
    logic order_r, order_nxt;
    logic [LANES-1:0] lanes_r, lanes_nxt;
    logic active_r, active_nxt;

    assign step.interleaved = order_nxt;
    assign step.start = start_nxt;
    assign step.count = count_nxt;

    always_comb
    begin
        base_nxt = base_r;
        start_nxt = start_r;
        count_nxt = count_r;
        op_nxt = op_r;
        order_nxt = order_r;
        lanes_nxt = lanes_r;
        active_nxt = active_r;
        if (tick)
        begin
            order_nxt = s_order;
            if (!s_adv)
            begin
                active_nxt = s_sel;
                if (s_sel)
                begin
                    base_nxt = s_addr[FULL_W-1 -: ADDR_W];
                    start_nxt = s_addr[1:0];
                    count_nxt = sram_port_pkg::BURST_ZERO;
                    op_nxt = s_we_n ? sram_port_pkg::OP_READ
                                    : sram_port_pkg::OP_WRITE;
                    lanes_nxt = ~s_lane_n;
                end
                else
                begin
                    op_nxt = sram_port_pkg::OP_IDLE;
                end
            end
            else if (active_r)
            begin
                count_nxt = count_r + sram_port_pkg::BURST_ONE;
                lanes_nxt = ~s_lane_n;
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            base_r <= '0;
            start_r <= sram_port_pkg::BURST_ZERO;
            count_r <= sram_port_pkg::BURST_ZERO;
            op_r <= sram_port_pkg::OP_IDLE;
            order_r <= sram_port_pkg::BURST_INTERLEAVED;
            lanes_r <= '0;
            active_r <= 1'b0;
        end
        else
        begin
            base_r <= base_nxt;
            start_r <= start_nxt;
            count_r <= count_nxt;
            op_r <= op_nxt;
            order_r <= order_nxt;
            lanes_r <= lanes_nxt;
            active_r <= active_nxt;
        end
    end

    // ----------------------------------------
    // Pipeline toward the data phase
    // ----------------------------------------
    logic [FULL_W-1:0] cur_addr;
    assign cur_addr = {base_nxt, step.offset};

    logic [FULL_W-1:0] pa_r [LAG];
    logic [FULL_W-1:0] pa_nxt [LAG];
    logic [LAG-1:0] pw_r, pw_nxt;
    logic [LAG-1:0] pr_r, pr_nxt;
    logic [LANES-1:0] pl_r [LAG];
    logic [LANES-1:0] pl_nxt [LAG];
    logic was_idle_r, was_idle_nxt;
    logic rd_en_r, rd_en_nxt;
    logic [LANES*LANE_W-1:0] rdata_r, rdata_nxt;
    logic [LANES-1:0] rpar_r, rpar_nxt;
    logic [LANES*LANE_W-1:0] mem_d [DEPTH];
    logic [LANES-1:0] mem_p [DEPTH];

    always_comb
    begin
        for (int i = 0; i < LAG; i++)
        begin
            pa_nxt[i] = pa_r[i];
            pl_nxt[i] = pl_r[i];
        end
        pw_nxt = pw_r;
        pr_nxt = pr_r;
        was_idle_nxt = was_idle_r;
        rd_en_nxt = rd_en_r;
        rdata_nxt = rdata_r;
        rpar_nxt = rpar_r;
        if (tick)
        begin
            pa_nxt[0] = cur_addr;
            pl_nxt[0] = lanes_nxt;
            pw_nxt[0] = active_nxt && (op_nxt == sram_port_pkg::OP_WRITE);
            pr_nxt[0] = active_nxt && (op_nxt == sram_port_pkg::OP_READ);
            for (int i = 1; i < LAG; i++)
            begin
                pa_nxt[i] = pa_r[i-1];
                pl_nxt[i] = pl_r[i-1];
                pw_nxt[i] = pw_r[i-1];
                pr_nxt[i] = pr_r[i-1];
            end
            was_idle_nxt = !active_r;
            // Read data leaves the output register one stage after the address
            rdata_nxt = mem_d[pa_r[0]];
            rpar_nxt = mem_p[pa_r[0]];
            rd_en_nxt = pr_r[0] && !was_idle_r && !pw_nxt[LAG-1];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            for (int i = 0; i < LAG; i++)
            begin
                pa_r[i] <= '0;
                pl_r[i] <= '0;
            end
            pw_r <= '0;
            pr_r <= '0;
            was_idle_r <= 1'b1;
            rd_en_r <= 1'b0;
            rdata_r <= '0;
            rpar_r <= '0;
        end
        else
        begin
            pa_r <= pa_nxt;
            pl_r <= pl_nxt;
            pw_r <= pw_nxt;
            pr_r <= pr_nxt;
            was_idle_r <= was_idle_nxt;
            rd_en_r <= rd_en_nxt;
            rdata_r <= rdata_nxt;
            rpar_r <= rpar_nxt;
        end
    end

    // ----------------------------------------
    // Array write in the data phase
    // ----------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (tick && pw_r[LAG-1] && s_oe_n)
        begin
            for (int l = 0; l < LANES; l++)
            begin
                if (pl_r[LAG-1][l])
                begin
                    mem_d[pa_r[LAG-1]][l*LANE_W +: LANE_W] <= din_sync_r[l*LANE_W +: LANE_W];
                    mem_p[pa_r[LAG-1]][l] <= par_sync_r[l];
                end
            end
        end
    end

    // ----------------------------------------
    // Data pin direction
    // ----------------------------------------
    logic drive;
    assign drive = rd_en_r && !output_enable_n_i;
    assign data_out_o = rdata_r;
    assign lane_parity_out_o = rpar_r;
    assign data_oe_o = drive;
    assign lane_parity_oe_o = drive;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence idle_edge_s;
        !tick;
    endsequence

    hold_on_stall_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        idle_edge_s |=> (base_r == $past(base_r)) && (count_r == $past(count_r)))
        else $error("state moved on an unqualified edge");
    load_addr_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        tick && !s_adv && s_sel |=> base_r == $past(s_addr[FULL_W-1 -: ADDR_W]))
        else $error("address not loaded");
    advance_cnt_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        tick && s_adv && active_r |=> count_r == $past(count_r) + 2'h1)
        else $error("burst counter did not step");
    select_decode_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        tick && !s_adv |=> active_r == $past(!pin_sync_r[4] && pin_sync_r[3] && !pin_sync_r[2]))
        else $error("select decode wrong");
    write_cmd_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        tick && !s_adv && s_sel && !s_we_n |=> op_r == sram_port_pkg::OP_WRITE)
        else $error("write command missed");
    oe_masked_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        output_enable_n_i |-> !data_oe_o)
        else $error("pins driven while released");
    no_drive_write_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        pw_r[LAG-1] |-> !data_oe_o)
        else $error("drivers on in write data phase");
    read_lanes_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        tick && !s_adv && s_sel |=> lanes_r == $past(~s_lane_n))
        else $error("lane selects not captured");

endmodule

`default_nettype wire

//--- sram_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none

module sram_ctl_model (
    input wire logic sys_clk_i,
    input wire logic [31:0] dev_d_i,
    input wire logic [3:0] dev_p_i,
    input wire logic dev_oe_i,
    output logic [17:0] addr_o,
    output logic [1:0] lo_o,
    output logic [3:0] sel_n_o,
    output logic wr_n_o,
    output logic adv_o,
    output logic q_n_o,
    output logic [2:0] cs_o,
    output logic [31:0] d_o,
    output logic [3:0] p_o
);
    // ----------------------------------------
    // Controller pins and shared data wire
    // ----------------------------------------
    logic [31:0] wd_r = 32'h0000_0000;
    logic [31:0] wq1_r = 32'h0000_0000;
    logic [31:0] wq2_r = 32'h0000_0000;
    logic wv1_r = 1'b0;
    logic wv2_r = 1'b0;
    logic [3:0] cnt_r = 4'h0;

    initial
    begin
        addr_o = 18'h0_0000;
        lo_o = 2'h0;
        sel_n_o = 4'hf;
        wr_n_o = 1'b1;
        adv_o = 1'b0;
        q_n_o = 1'b0;
        cs_o = 3'b111;
    end

    // Put write data on the wire two cycles after the command, for as long as the qualified write command is held
    always @(posedge sys_clk_i)
    begin
        cnt_r <= cnt_r + 4'h1;
        wq1_r <= wd_r;
        wv1_r <= !wr_n_o && !q_n_o;
        wq2_r <= wq1_r;
        wv2_r <= wv1_r;
    end

    // Released wire shows a changing pattern
    assign d_o = wv2_r ? wq2_r : (dev_oe_i ? dev_d_i : {8{cnt_r}});
    assign p_o = wv2_r ? wq2_r[3:0] ^ 4'ha : (dev_oe_i ? dev_p_i : cnt_r);

    task automatic issue(input logic w, input logic a, input logic [17:0] ad,
        input logic [1:0] lo, input logic [3:0] m, input logic [31:0] d,
        input logic q, input logic [2:0] cs);
        @(posedge sys_clk_i);
        #1;
        wr_n_o = !w;
        adv_o = a;
        addr_o = ad;
        lo_o = lo;
        sel_n_o = m;
        wd_r = d;
        q_n_o = q;
        cs_o = cs;
    endtask
endmodule

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // ----------------------------------------
    // Clock, reset and wiring
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic strap = 1'b1;
    logic oe_n = 1'b0;
    int err_count = 0;
    int samples_checked = 0;
    logic [17:0] ad;
    logic [1:0] lo;
    logic [3:0] sn;
    logic wn, adv, qn, doe, poe;
    logic [2:0] cs;
    logic [31:0] dw, dout;
    logic [3:0] pw_, pout;

    always #20 clk = ~clk;

    sram_ctl_model ctl (.sys_clk_i(clk), .dev_d_i(dout), .dev_p_i(pout), .dev_oe_i(doe),
        .addr_o(ad), .lo_o(lo), .sel_n_o(sn), .wr_n_o(wn), .adv_o(adv), .q_n_o(qn),
        .cs_o(cs), .d_o(dw), .p_o(pw_));

    sync_pipelined_sram_port uut (.sys_clk_i(clk), .reset_n_i(rst_n), .addr_i(ad),
        .burst_addr_bit0_i(lo[0]), .burst_addr_bit1_i(lo[1]),
        .lane_a_write_sel_n_i(sn[0]), .lane_b_write_sel_n_i(sn[1]),
        .lane_c_write_sel_n_i(sn[2]), .lane_d_write_sel_n_i(sn[3]),
        .write_n_i(wn), .advance_or_load_i(adv), .clock_qualify_n_i(qn),
        .select_first_n_i(cs[2]), .select_second_i(cs[1]), .select_third_n_i(cs[0]),
        .output_enable_n_i(oe_n), .burst_order_i(strap), .data_in_i(dw),
        .data_out_o(dout), .data_oe_o(doe), .lane_parity_in_i(pw_),
        .lane_parity_out_o(pout), .lane_parity_oe_o(poe));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [35:0] pw(input logic [31:0] d);
        return {d[3:0] ^ 4'ha, d};
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic chk_word(input logic [35:0] e, input logic [35:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic chk_bit(input logic e, input logic g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic wr(input logic [17:0] a, input logic [1:0] l, input logic [3:0] m,
        input logic [31:0] d);
        ctl.issue(1'b1, 1'b0, a, l, m, d, 1'b0, 3'b010);
        oe_n = 1'b1;
        step(6);
        chk_bit(1'b0, doe);
        chk_bit(1'b0, poe);
    endtask

    task automatic rd(input logic [17:0] a, input logic [1:0] l, input logic [35:0] e);
        ctl.issue(1'b0, 1'b0, a, l, 4'hf, 32'h0000_0000, 1'b0, 3'b010);
        oe_n = 1'b0;
        step(6);
        chk_bit(1'b1, doe);
        chk_word(e, {pout, dout});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_basic;
        wr(18'h0_0123, 2'h0, 4'h0, 32'hdead_beef);
        wr(18'h0_0124, 2'h0, 4'h0, 32'h0123_4567);
        rd(18'h0_0123, 2'h0, pw(32'hdead_beef));
        rd(18'h0_0124, 2'h0, pw(32'h0123_4567));
    endtask

    task automatic sc_lanes;
        logic [35:0] e;
        logic [3:0] k;
        k = 4'ha;
        for (int i = 0; i < 4; i++)
        begin
            wr(18'h0_0200, 2'h0, 4'h0, 32'hffff_ffff);
            wr(18'h0_0200, 2'h0, ~(4'h1 << i), 32'h0000_0000);
            e = pw(32'hffff_ffff);
            e[i*8 +: 8] = 8'h00;
            e[32+i] = k[i];
            rd(18'h0_0200, 2'h0, e);
        end
    endtask

    task automatic sc_oe;
        rd(18'h0_0123, 2'h0, pw(32'hdead_beef));
        @(posedge clk);
        #1;
        oe_n = 1'b1;
        #1;
        chk_bit(1'b0, doe);
        oe_n = 1'b0;
        #1;
        chk_bit(1'b1, doe);
    endtask

    task automatic sc_select;
        for (int k = 0; k < 8; k++)
        begin
            ctl.issue(1'b0, 1'b0, 18'h0_0123, 2'h0, 4'hf, 32'h0000_0000, 1'b0, k[2:0]);
            step(6);
            chk_bit(k == 2, doe);
        end
    endtask

    task automatic sc_first;
        ctl.issue(1'b0, 1'b0, 18'h0_0123, 2'h0, 4'hf, 32'h0000_0000, 1'b0, 3'b111);
        step(6);
        ctl.issue(1'b0, 1'b0, 18'h0_0123, 2'h0, 4'hf, 32'h0000_0000, 1'b0, 3'b010);
        step(4);
        chk_bit(1'b0, doe);
        step(2);
        chk_bit(1'b1, doe);
    endtask

    task automatic sc_qual;
        rd(18'h0_0123, 2'h0, pw(32'hdead_beef));
        ctl.issue(1'b0, 1'b0, 18'h0_0124, 2'h0, 4'hf, 32'h0000_0000, 1'b1, 3'b010);
        step(8);
        chk_word(pw(32'hdead_beef), {pout, dout});
        chk_bit(1'b1, doe);
        ctl.issue(1'b1, 1'b0, 18'h0_0124, 2'h0, 4'h0, 32'h5555_aaaa, 1'b1, 3'b010);
        step(8);
        rd(18'h0_0124, 2'h0, pw(32'h0123_4567));
    endtask

    task automatic sc_burst;
        logic [31:0] v;
        int off;
        for (int o = 0; o < 2; o++)
        begin
            strap = (o == 0);
            for (int k = 0; k < 4; k++)
                wr(18'h0_0300, k[1:0], 4'h0, 32'h5a5a_0000 | k);
            oe_n = 1'b0;
            for (int k = 0; k < 4; k++)
                ctl.issue(1'b0, k != 0, 18'h0_0300, 2'h1, 4'hf, 32'h0, 1'b0, 3'b010);
            ctl.issue(1'b0, 1'b0, 18'h0_0300, 2'h1, 4'hf, 32'h0, 1'b0, 3'b010);
            for (int k = 0; k < 4; k++)
            begin
                off = (o == 0) ? (1 ^ k) : ((1 + k) % 4);
                v = 32'h5a5a_0000;
                v[1:0] = off[1:0];
                chk_word(pw(v), {pout, dout});
                step(1);
            end
        end
    endtask

    // ----------------------------------------
    // Sequence and verdict
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #(40 * 5000);
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        #1;
        chk_bit(1'b0, doe);
        chk_word(36'h0_0000_0000, {pout, dout});
        rst_n = 1'b1;
        sc_basic();
        sc_lanes();
        sc_oe();
        sc_select();
        sc_first();
        sc_qual();
        sc_burst();
        tally_and_finish();
    end
endmodule

`default_nettype wire
